// [src/dbsp_map.svh]
// Constants of the burst-of-two double-data-rate SRAM port.
// Assumes inclusion by the port module only; holds definitions alone.
`ifndef DBSP_MAP_SVH
`define DBSP_MAP_SVH

// ----------------------------------------------------------------
// Field layout
// ----------------------------------------------------------------
`define DBSP_LANE_W      9
`define DBSP_BEATS       2
`define DBSP_ADDR_W_X18  20
`define DBSP_ADDR_W_X36  19
`define DBSP_WIDTH_X18   18
`define DBSP_WIDTH_X36   36

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define DBSP_CNT_RST     2'h0
`define DBSP_OE_RST      1'b0
`define DBSP_ECHO_RST    1'b0

`endif

// [src/dbsp_pkg.sv]
// Types shared by the burst-of-two SRAM port.
// Assumes no other package.
package dbsp_pkg;

  // ----------------------------------------------------------------
  // Sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    DBSP_IDLE = 3'b000,
    DBSP_WR0  = 3'b001,
    DBSP_WR1  = 3'b010,
    DBSP_RD0  = 3'b011,
    DBSP_RD1  = 3'b100
  } dbsp_state_t;

  // ----------------------------------------------------------------
  // Loaded command, address held at its widest
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        rd;
    logic [19:0] addr;
  } dbsp_cmd_t;

endpackage

// [src/dbsp_port.sv]
// Burst-of-two double-data-rate SRAM port, memory side, with its array.
// Assumes all pins come from the outside world and are resynchronised
// here on a 50 MHz system clock that is several times the pin clocks.
`timescale 1ns/10ps
`include "dbsp_map.svh"

module dbsp_port #(
  parameter int WIDTH  = `DBSP_WIDTH_X18,
  parameter int ADDR_W = `DBSP_ADDR_W_X18
) (
  input  wire logic                                 clock,
  input  wire logic                                 rstn,
  input  wire logic                                 k,
  input  wire logic                                 k_n,
  input  wire logic                                 c,
  input  wire logic                                 c_n,
  input  wire logic                                 cycle_load_n,
  input  wire logic                                 read_write,
  input  wire logic [ADDR_W-1:0]                    addr,
  input  wire logic [WIDTH/`DBSP_LANE_W-1:0]        byte_lane_select_n,
  input  wire logic [WIDTH-1:0]                     dq_in,
  output logic      [WIDTH-1:0]                     dq_out,
  output logic                                      dq_oe,
  output logic                                      echo_timing_pair,
  output logic                                      echo_timing_pair_n
);

  localparam int LANES = WIDTH / `DBSP_LANE_W;
  localparam int PW    = 6 + ADDR_W + LANES + WIDTH;

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (!((WIDTH == `DBSP_WIDTH_X18 && ADDR_W == `DBSP_ADDR_W_X18) ||
        (WIDTH == `DBSP_WIDTH_X36 && ADDR_W == `DBSP_ADDR_W_X36))) begin : g_bad_cfg
    $error("dbsp_port: unsupported WIDTH/ADDR_W pair");
  end

  // ----------------------------------------------------------------
  // Lane merge
  // ----------------------------------------------------------------
  // lane discard
  function automatic logic [WIDTH-1:0] merge_lanes(input logic [WIDTH-1:0] old_w,
                                                   input logic [WIDTH-1:0] new_w,
                                                   input logic [LANES-1:0] sel_n);
    logic [WIDTH-1:0] res;
    res = old_w;
    for (int i = 0; i < LANES; i++) begin
      if (!sel_n[i]) begin
        res[i*`DBSP_LANE_W +: `DBSP_LANE_W] = new_w[i*`DBSP_LANE_W +: `DBSP_LANE_W];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [PW-1:0] pin_meta_q;
  logic [PW-1:0] pin_q;
  logic [3:0]    clk_hist_q;
  logic [2:0]    sync_fill_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pin_meta_q  <= '0;
      pin_q       <= '0;
      clk_hist_q  <= 4'h0;
      sync_fill_q <= 3'h0;
    end else begin
      pin_meta_q  <= {k, k_n, c, c_n, cycle_load_n, read_write, addr,
                      byte_lane_select_n, dq_in};
      pin_q       <= pin_meta_q;
      clk_hist_q  <= pin_q[PW-1 -: 4];
      // History holds real pin levels after three edges
      sync_fill_q <= {sync_fill_q[1:0], 1'b1};
    end
  end

  logic              k_s;
  logic              kn_s;
  logic              c_s;
  logic              cn_s;
  logic              load_n_s;
  logic              rw_s;
  logic [ADDR_W-1:0] addr_s;
  logic [LANES-1:0]  sel_n_s;
  logic [WIDTH-1:0]  din_s;

  assign {k_s, kn_s, c_s, cn_s, load_n_s, rw_s, addr_s, sel_n_s, din_s} = pin_q;

  logic k_rise;
  logic kn_rise;
  logic c_rise;
  logic cn_rise;
  logic single_mode;
  logic out_edge;

  // No false edge while the pipes still hold reset zeros
  assign k_rise      = sync_fill_q[2] & k_s & ~clk_hist_q[3];
  assign kn_rise     = sync_fill_q[2] & kn_s & ~clk_hist_q[2];
  assign c_rise      = sync_fill_q[2] & c_s & ~clk_hist_q[1];
  assign cn_rise     = sync_fill_q[2] & cn_s & ~clk_hist_q[0];
  assign single_mode = c_s & cn_s;
  assign out_edge    = single_mode ? (k_rise | kn_rise) : (c_rise | cn_rise);

  // ----------------------------------------------------------------
  // Array and sequencer
  // ----------------------------------------------------------------
  logic [WIDTH-1:0]    mem [2**ADDR_W];
  dbsp_pkg::dbsp_state_t state_q;
  dbsp_pkg::dbsp_cmd_t   cmd_q;
  logic [ADDR_W-1:0]   beat_addr;
  logic [1:0]          cnt_q;
  logic                buf_ready;
  logic                push;

  assign buf_ready = (cnt_q != 2'h2);
  assign beat_addr = (state_q == dbsp_pkg::DBSP_WR1 || state_q == dbsp_pkg::DBSP_RD1) ?
                     {cmd_q.addr[ADDR_W-1:1], ~cmd_q.addr[0]} : cmd_q.addr[ADDR_W-1:0];
  assign push      = buf_ready && cmd_q.rd &&
                     (state_q == dbsp_pkg::DBSP_RD0 || state_q == dbsp_pkg::DBSP_RD1);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      state_q <= dbsp_pkg::DBSP_IDLE;
      cmd_q   <= '0;
    end else begin
      unique case (state_q)
        dbsp_pkg::DBSP_IDLE: begin
          if (k_rise && !load_n_s) begin
            cmd_q.addr <= 20'(addr_s);
            cmd_q.rd   <= rw_s;
            state_q    <= rw_s ? dbsp_pkg::DBSP_RD0 : dbsp_pkg::DBSP_WR0;
          end
        end
        dbsp_pkg::DBSP_WR0: begin
          if (k_rise) begin
            state_q <= dbsp_pkg::DBSP_WR1;
          end
        end
        dbsp_pkg::DBSP_WR1: begin
          if (kn_rise) begin
            state_q <= dbsp_pkg::DBSP_IDLE;
          end
        end
        dbsp_pkg::DBSP_RD0: begin
          if (buf_ready) begin
            state_q <= dbsp_pkg::DBSP_RD1;
          end
        end
        dbsp_pkg::DBSP_RD1: begin
          if (buf_ready) begin
            state_q <= dbsp_pkg::DBSP_IDLE;
          end
        end
        default: begin
          state_q <= dbsp_pkg::DBSP_IDLE;
        end
      endcase
    end
  end

  // Array write, lanes merged per beat
  always_ff @(posedge clock) begin
    if ((state_q == dbsp_pkg::DBSP_WR0 && k_rise) ||
        (state_q == dbsp_pkg::DBSP_WR1 && kn_rise)) begin
      mem[beat_addr] <= merge_lanes(mem[beat_addr], din_s, sel_n_s);
    end
  end

  // ----------------------------------------------------------------
  // Two-entry read buffer
  // ----------------------------------------------------------------
  logic [WIDTH-1:0] ent0_q;
  logic [WIDTH-1:0] ent1_q;
  logic [WIDTH-1:0] rd_word;
  logic             pop;

  assign rd_word = mem[beat_addr];
  assign pop     = out_edge && (cnt_q != 2'h0);

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      cnt_q  <= `DBSP_CNT_RST;
      ent0_q <= '0;
      ent1_q <= '0;
    end else begin
      unique case ({push, pop})
        2'b10: begin
          if (cnt_q == 2'h0) begin
            ent0_q <= rd_word;
          end else begin
            ent1_q <= rd_word;
          end
          cnt_q <= cnt_q + 2'h1;
        end
        2'b01: begin
          ent0_q <= ent1_q;
          cnt_q  <= cnt_q - 2'h1;
        end
        2'b11: begin
          if (cnt_q == 2'h1) begin
            ent0_q <= rd_word;
          end else begin
            ent0_q <= ent1_q;
            ent1_q <= rd_word;
          end
        end
        2'b00: begin
          cnt_q <= cnt_q;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Data drivers and echo clocks
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      dq_out <= '0;
      dq_oe  <= `DBSP_OE_RST;
    end else if (out_edge) begin
      dq_oe <= pop;
      if (pop) begin
        dq_out <= ent0_q;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      echo_timing_pair   <= `DBSP_ECHO_RST;
      echo_timing_pair_n <= `DBSP_ECHO_RST;
    end else begin
      echo_timing_pair   <= single_mode ? k_s : c_s;
      echo_timing_pair_n <= single_mode ? kn_s : cn_s;
    end
  end

endmodule

// [bench/dbsp_port_chk.sv]
// Checker for the burst-of-two SRAM port, bound to its top module.
// Assumes slow pin clocks, C pair complementary or both high.
`timescale 1ns/10ps
module dbsp_port_chk #(
  parameter int WIDTH  = 18,
  parameter int ADDR_W = 20
) (
  input wire logic               clock,
  input wire logic               rstn,
  input wire logic               k,
  input wire logic               k_n,
  input wire logic               c,
  input wire logic               c_n,
  input wire logic               cycle_load_n,
  input wire logic               read_write,
  input wire logic [ADDR_W-1:0]  addr,
  input wire logic [WIDTH/9-1:0] byte_lane_select_n,
  input wire logic [WIDTH-1:0]   dq_in,
  input wire logic [WIDTH-1:0]   dq_out,
  input wire logic               dq_oe,
  input wire logic               echo_timing_pair,
  input wire logic               echo_timing_pair_n
);
  // ----
  // Pin history at the port's synchroniser delay
  // ----
  logic [4:0] ch_q, cnh_q, kh_q, knh_q;
  logic [3:0] rh_q;
  logic [2:0] edges_q;
  logic       seen_rd_q;
  logic       sgl;
  logic       oedge;
  logic       recent;
  assign sgl    = ch_q[2] & cnh_q[2];
  assign oedge  = sgl ? (kh_q[2] & ~kh_q[3]) | (knh_q[2] & ~knh_q[3])
                      : (ch_q[2] & ~ch_q[3]) | (cnh_q[2] & ~cnh_q[3]);
  assign recent = sgl ? |(kh_q[3:1] & ~kh_q[4:2]) || |(knh_q[3:1] & ~knh_q[4:2])
                      : |(ch_q[3:1] & ~ch_q[4:2]) || |(cnh_q[3:1] & ~cnh_q[4:2]);
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      {ch_q, cnh_q, kh_q, knh_q} <= '0;
      rh_q <= 4'h0;
    end else begin
      ch_q  <= {ch_q[3:0], c};
      cnh_q <= {cnh_q[3:0], c_n};
      kh_q  <= {kh_q[3:0], k};
      knh_q <= {knh_q[3:0], k_n};
      rh_q  <= {rh_q[2:0], 1'b1};
    end
  end
  // Output edges seen since the last read load
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      edges_q   <= 3'h0;
      seen_rd_q <= 1'b0;
    end else if (!cycle_load_n && read_write) begin
      edges_q   <= 3'h0;
      seen_rd_q <= 1'b1;
    end else if (oedge && edges_q != 3'h7) begin
      edges_q <= edges_q + 3'h1;
    end
  end
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  sequence s_rd_load;
    !cycle_load_n && read_write;
  endsequence
  sequence s_burst_out;
    dq_oe [*2];
  endsequence
  a_echo_normal: assert property (&rh_q && !sgl |-> echo_timing_pair == ch_q[2])
    else $error("echo level differs from c");
  a_echo_single: assert property (&rh_q && sgl |-> echo_timing_pair == kh_q[2])
    else $error("echo level differs from k");
  a_echo_comp: assert property (&rh_q |-> echo_timing_pair_n == (sgl ? knh_q[2] : cnh_q[2]))
    else $error("inverted echo level wrong");
  a_out_on_edge: assert property (&rh_q && $changed(dq_out) |-> recent)
    else $error("read data moved without an output edge");
  a_oe_on_edge: assert property (&rh_q && $changed(dq_oe) |-> recent)
    else $error("output enable moved without an output edge");
  a_reset_quiet: assert property ($rose(rstn) |-> !dq_oe && !echo_timing_pair)
    else $error("outputs active right after reset");
  a_oe_before_read: assert property (!seen_rd_q |-> !dq_oe)
    else $error("output enable before any read");
  a_oe_burst_end: assert property (edges_q >= 3'h4 |-> !dq_oe)
    else $error("output enable held past the burst");
  c_read_burst: cover property (s_rd_load ##[1:60] s_burst_out);
endmodule
bind dbsp_port dbsp_port_chk #(.WIDTH(WIDTH), .ADDR_W(ADDR_W)) u_dbsp_port_chk (
  .clock(clock), .rstn(rstn), .k(k), .k_n(k_n), .c(c), .c_n(c_n),
  .cycle_load_n(cycle_load_n), .read_write(read_write), .addr(addr),
  .byte_lane_select_n(byte_lane_select_n), .dq_in(dq_in), .dq_out(dq_out),
  .dq_oe(dq_oe), .echo_timing_pair(echo_timing_pair),
  .echo_timing_pair_n(echo_timing_pair_n));

// [bench/dbsp_host.sv]
// Host controller model: makes K and C pairs, loads, write beats.
// Assumes a 50 MHz clock; one pin phase lasts six clocks.
`timescale 1ns/10ps
module dbsp_host #(
  parameter int WIDTH  = 18,
  parameter int ADDR_W = 20
) (
  input wire logic               clock,
  output logic                   k,
  output logic                   k_n,
  output logic                   c,
  output logic                   c_n,
  output logic                   cycle_load_n,
  output logic                   read_write,
  output logic [ADDR_W-1:0]      addr,
  output logic [WIDTH/9-1:0]     byte_lane_select_n,
  output logic [WIDTH-1:0]       dq_in,
  input wire logic [WIDTH-1:0]   dq_out,
  input wire logic               dq_oe
);
  logic             single = 1'b0;
  logic             grab = 1'b0;
  logic [WIDTH-1:0] got [$];
  initial begin
    {k, c, read_write, addr, dq_in} = '0;
    {k_n, c_n, cycle_load_n, byte_lane_select_n} = '1;
  end
  // C pair tracks K, or stands high
  task automatic half(input logic lvl);
    k = lvl;
    k_n = ~lvl;
    c = single | lvl;
    c_n = single | ~lvl;
    repeat (6) @(posedge clock);
    #1;
    if (grab && dq_oe === 1'b1) got.push_back(dq_out);
  endtask
  // load strobe for one K period
  task automatic load(input logic rd, input logic [ADDR_W-1:0] a);
    cycle_load_n = 1'b0;
    read_write = rd;
    addr = a;
    half(1'b1);
    half(1'b0);
    cycle_load_n = 1'b1;
    read_write = ~rd;
    addr = ~a;
  endtask
  // each beat with its own selects
  task automatic write(input logic [ADDR_W-1:0] a, input logic [WIDTH-1:0] d0, d1,
                       input logic [WIDTH/9-1:0] s0, s1);
    load(1'b0, a);
    dq_in = d0;
    byte_lane_select_n = s0;
    half(1'b1);
    dq_in = d1;
    byte_lane_select_n = s1;
    half(1'b0);
    dq_in = ~d1;
    byte_lane_select_n = ~s1;
  endtask
  // K runs with load strobe high, write-like pins
  task automatic idle(input logic [ADDR_W-1:0] a, input logic [WIDTH-1:0] d);
    read_write = 1'b0;
    addr = a;
    dq_in = d;
    byte_lane_select_n = '0;
    repeat (2) begin
      half(1'b1);
      half(1'b0);
    end
  endtask
  task automatic read(input logic [ADDR_W-1:0] a);
    got.delete();
    grab = 1'b1;
    load(1'b1, a);
    repeat (4) begin
      half(1'b1);
      half(1'b0);
    end
    grab = 1'b0;
  endtask
endmodule

// [bench/tb.sv]
// Self-checking bench for the SRAM port, 18-bit organisation.
// Assumes the host model drives all pins and gathers read words.
`timescale 1ns/10ps
module tb;
  localparam logic [17:0] D0 = 18'h1_2345;
  localparam logic [17:0] D1 = 18'h2_abcd;
  localparam logic [17:0] P  = 18'h3_ffff;
  logic        clock;
  logic        rstn;
  logic        k, k_n, c, c_n, cycle_load_n, read_write, dq_oe;
  logic [19:0] addr;
  logic [1:0]  byte_lane_select_n;
  logic [17:0] dq_in, dq_out;
  int          n_fail;
  int          total_checks;
  dbsp_port u_dbsp_port (.clock(clock), .rstn(rstn), .k(k), .k_n(k_n), .c(c), .c_n(c_n),
    .cycle_load_n(cycle_load_n), .read_write(read_write), .addr(addr),
    .byte_lane_select_n(byte_lane_select_n), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe), .echo_timing_pair(), .echo_timing_pair_n());
  dbsp_host u_dbsp_host (.clock(clock), .k(k), .k_n(k_n), .c(c), .c_n(c_n),
    .cycle_load_n(cycle_load_n), .read_write(read_write), .addr(addr),
    .byte_lane_select_n(byte_lane_select_n), .dq_in(dq_in), .dq_out(dq_out),
    .dq_oe(dq_oe));
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  task automatic check(input string what, input logic [17:0] exp, input logic [17:0] seen);
    total_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic rd_check(input logic [19:0] a, input logic [17:0] w0, w1);
    u_dbsp_host.read(a);
    check("word count", 18'h0_0002, 18'(u_dbsp_host.got.size()));
    check("word 0", w0, u_dbsp_host.got[0]);
    check("word 1", w1, u_dbsp_host.got[1]);
    check("enable after burst", 18'h0_0000, {17'h0_0000, dq_oe});
  endtask
  task automatic t_full();
    u_dbsp_host.write(20'h0_0004, D0, D1, 2'h0, 2'h0);
    rd_check(20'h0_0004, D0, D1);
    $display("test full_burst done");
  endtask
  task automatic t_wrap();
    u_dbsp_host.write(20'h0_0007, D1, D0, 2'h0, 2'h0);
    rd_check(20'h0_0006, D0, D1);
    $display("test wrap_pair done");
  endtask
  task automatic t_lanes();
    u_dbsp_host.write(20'h0_0004, P, P, 2'h1, 2'h2);
    rd_check(20'h0_0004, {P[17:9], D0[8:0]}, {D1[17:9], P[8:0]});
    $display("test lane_select done");
  endtask
  task automatic t_idle();
    u_dbsp_host.idle(20'h0_0004, P);
    rd_check(20'h0_0004, {P[17:9], D0[8:0]}, {D1[17:9], P[8:0]});
    $display("test unloaded_k done");
  endtask
  task automatic t_single();
    u_dbsp_host.single = 1'b1;
    rd_check(20'h0_0006, D0, D1);
    u_dbsp_host.single = 1'b0;
    $display("test single_clock done");
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge clock);
    n_fail++;
    stop_test();
  end
  initial begin
    n_fail = 0;
    total_checks = 0;
    rstn = 1'b0;
    repeat (5) @(posedge clock);
    #1 rstn = 1'b1;
    repeat (4) @(posedge clock);
    #1;
    t_full();
    t_wrap();
    t_lanes();
    t_idle();
    t_single();
    stop_test();
  end
endmodule
